// ---- rtl/ccl_pkg.sv ----
// Purpose: shared constants for the comparator control logic
// Assumes: 8-bit register data, data-space byte addresses
// Notes:   i/o space address = data-space address minus io offset
package ccl_pkg;
    // register addresses and i/o window
    localparam logic [7:0] CCL_CCS_ADDR      = 8'h50;
    localparam logic [7:0] CCL_CCB_ADDR      = 8'h7b;
    localparam logic [7:0] CCL_IO_OFFSET     = 8'h20;
    localparam logic [7:0] CCL_IO_LAST       = 8'h3f;
    localparam logic [7:0] CCL_ZERO_BYTE     = 8'h00;

    // comparator_control_status fields
    localparam int CCL_CCS_DISABLE_BIT       = 7;
    localparam int CCL_CCS_BANDGAP_BIT       = 6;
    localparam int CCL_CCS_OUTPUT_BIT        = 5;
    localparam int CCL_CCS_FLAG_BIT          = 4;
    localparam int CCL_CCS_IE_BIT            = 3;
    localparam int CCL_CCS_CAPTURE_BIT       = 2;
    localparam int CCL_CCS_MODE_HI           = 1;
    localparam int CCL_CCS_MODE_LO           = 0;

    // converter_control_b fields
    localparam int CCL_CCB_MUX_EN_BIT        = 6;
    localparam int CCL_CCB_TSRC_HI           = 2;
    localparam int CCL_CCB_TSRC_LO           = 0;

    // comparator_irq_mode codes
    localparam logic [1:0] CCL_MODE_TOGGLE   = 2'h0;
    localparam logic [1:0] CCL_MODE_RESERVED = 2'h1;
    localparam logic [1:0] CCL_MODE_FALL     = 2'h2;
    localparam logic [1:0] CCL_MODE_RISE     = 2'h3;

    // trigger_source_select codes
    localparam logic [2:0] CCL_TSRC_FREE     = 3'h0;
    localparam logic [2:0] CCL_TSRC_COMP     = 3'h1;
    localparam logic [2:0] CCL_TSRC_EXT0     = 3'h2;
    localparam logic [2:0] CCL_TSRC_T0CMPA   = 3'h3;
    localparam logic [2:0] CCL_TSRC_T0OVF    = 3'h4;
    localparam logic [2:0] CCL_TSRC_T1CMPB   = 3'h5;
    localparam logic [2:0] CCL_TSRC_T1OVF    = 3'h6;
    localparam logic [2:0] CCL_TSRC_T1CAPT   = 3'h7;
endpackage

// ---- rtl/ccl_sync.sv ----
// Purpose: two-stage synchronizer for the raw comparator result
// Assumes: synchronous active-high reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module ccl_sync (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST,
    // data
    input  wire logic D_IN,
    output logic      Q_OUT
);
    typedef struct packed {
        logic stage1;
        logic stage2;
    } ccl_sync_t;

    ccl_sync_t st_r;
    ccl_sync_t st_nxt;

    always_comb begin
        st_nxt.stage1 = D_IN;
        st_nxt.stage2 = st_r.stage1;
        if (RST) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        st_r <= st_nxt;
    end

    assign Q_OUT = st_r.stage2;
endmodule

// ---- rtl/ccl_top.sv ----
// Purpose: control logic around the on-chip voltage comparator
// Assumes: cpu register port synchronous to SYS_CLK, RST synchronous high
// Notes:   converter_control_b is reachable only in data space
`timescale 1ns/10ps
module ccl_top
    import ccl_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    // cpu register port
    input  wire logic [7:0] BUS_ADDR,
    input  wire logic       BUS_IO,
    input  wire logic       BUS_WE,
    input  wire logic       BUS_RE,
    input  wire logic [7:0] BUS_WDATA,
    output logic      [7:0] BUS_RDATA,
    // analog comparator core
    input  wire logic       COMP_RAW,
    output logic            COMP_POWER_OFF,
    output logic            POS_USE_BANDGAP,
    output logic            NEG_USE_CHANNEL,
    output logic      [2:0] NEG_CHANNEL,
    // converter control state
    input  wire logic       CONVERTER_ENABLE,
    input  wire logic       AUTO_TRIGGER_ENABLE,
    input  wire logic [2:0] CHANNEL_SELECT_LOW,
    input  wire logic       CONVERSION_DONE_FLAG,
    // trigger source flags
    input  wire logic       EXT_INT0_FLAG,
    input  wire logic       T0_CMPA_FLAG,
    input  wire logic       T0_OVF_FLAG,
    input  wire logic       T1_CMPB_FLAG,
    input  wire logic       T1_OVF_FLAG,
    input  wire logic       T1_CAPT_FLAG,
    // interrupt system
    input  wire logic       GLOBAL_IRQ_ENABLE,
    input  wire logic       IRQ_VECTOR_ACK,
    output logic            COMP_IRQ,
    // timer capture and converter trigger
    output logic            CAPTURE_IN,
    output logic            CONV_TRIGGER
);
    typedef struct packed {
        logic       aco_prev;
        logic       irq_flag;
        logic       comp_disable;
        logic       bandgap_sel;
        logic       irq_enable;
        logic       capture_en;
        logic [1:0] irq_mode;
        logic       mux_enable;
        logic [2:0] tsrc;
        logic [2:0] tsrc_prev;
        logic       trig_prev;
        logic       trig;
        logic [7:0] rdata;
    } ccl_state_t;

    ccl_state_t st_r;
    ccl_state_t st_nxt;
    logic       comparator_output_bit;
    logic       edge_rise;
    logic       edge_fall;
    logic       irq_event;
    logic       hit_ccs;
    logic       hit_ccb;
    logic       trig_sel;
    logic       free_switch;
    logic [7:0] ccs_value;
    logic [7:0] ccb_value;

    // address decode for data space and i/o space
    function automatic logic ccl_hit(input logic [7:0] addr, input logic io, input logic [7:0] target);
        logic [7:0] full;
        full = 8'(addr + CCL_IO_OFFSET);
        if (io) begin
            ccl_hit = (addr <= CCL_IO_LAST) && (full == target);
        end else begin
            ccl_hit = (addr == target);
        end
    endfunction

    // raw comparator result into the clock domain
    ccl_sync u_sync (
        .SYS_CLK (SYS_CLK),
        .RST     (RST),
        .D_IN    (COMP_RAW),
        .Q_OUT   (comparator_output_bit)
    );

    always_comb begin
        hit_ccs = ccl_hit(BUS_ADDR, BUS_IO, CCL_CCS_ADDR);
        hit_ccb = ccl_hit(BUS_ADDR, BUS_IO, CCL_CCB_ADDR);

        // edge detect against previous sample
        edge_rise = comparator_output_bit && !st_r.aco_prev;
        edge_fall = !comparator_output_bit && st_r.aco_prev;
        unique case (st_r.irq_mode)
            CCL_MODE_TOGGLE:   irq_event = edge_rise || edge_fall;
            CCL_MODE_RESERVED: irq_event = 1'b0;
            CCL_MODE_FALL:     irq_event = edge_fall;
            CCL_MODE_RISE:     irq_event = edge_rise;
        endcase

        // trigger source selection
        unique case (st_r.tsrc)
            CCL_TSRC_FREE:   trig_sel = CONVERSION_DONE_FLAG;
            CCL_TSRC_COMP:   trig_sel = st_r.irq_flag;
            CCL_TSRC_EXT0:   trig_sel = EXT_INT0_FLAG;
            CCL_TSRC_T0CMPA: trig_sel = T0_CMPA_FLAG;
            CCL_TSRC_T0OVF:  trig_sel = T0_OVF_FLAG;
            CCL_TSRC_T1CMPB: trig_sel = T1_CMPB_FLAG;
            CCL_TSRC_T1OVF:  trig_sel = T1_OVF_FLAG;
            CCL_TSRC_T1CAPT: trig_sel = T1_CAPT_FLAG;
        endcase
        free_switch = (st_r.tsrc == CCL_TSRC_FREE) && (st_r.tsrc_prev != CCL_TSRC_FREE);

        // readable register images
        ccs_value = CCL_ZERO_BYTE;
        ccs_value[CCL_CCS_DISABLE_BIT] = st_r.comp_disable;
        ccs_value[CCL_CCS_BANDGAP_BIT] = st_r.bandgap_sel;
        ccs_value[CCL_CCS_OUTPUT_BIT] = comparator_output_bit;
        ccs_value[CCL_CCS_FLAG_BIT] = st_r.irq_flag;
        ccs_value[CCL_CCS_IE_BIT] = st_r.irq_enable;
        ccs_value[CCL_CCS_CAPTURE_BIT] = st_r.capture_en;
        ccs_value[CCL_CCS_MODE_HI:CCL_CCS_MODE_LO] = st_r.irq_mode;
        ccb_value = CCL_ZERO_BYTE;
        ccb_value[CCL_CCB_MUX_EN_BIT] = st_r.mux_enable;
        ccb_value[CCL_CCB_TSRC_HI:CCL_CCB_TSRC_LO] = st_r.tsrc;

        st_nxt = st_r;
        st_nxt.aco_prev = comparator_output_bit;
        st_nxt.tsrc_prev = st_r.tsrc;
        st_nxt.trig_prev = trig_sel;

        // rising edge of selected flag starts a conversion
        st_nxt.trig = AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE && trig_sel
                      && !st_r.trig_prev && !free_switch;

        // register writes
        if (BUS_WE && hit_ccs) begin
            st_nxt.comp_disable = BUS_WDATA[CCL_CCS_DISABLE_BIT];
            st_nxt.bandgap_sel = BUS_WDATA[CCL_CCS_BANDGAP_BIT];
            st_nxt.irq_enable = BUS_WDATA[CCL_CCS_IE_BIT];
            st_nxt.capture_en = BUS_WDATA[CCL_CCS_CAPTURE_BIT];
            st_nxt.irq_mode = BUS_WDATA[CCL_CCS_MODE_HI:CCL_CCS_MODE_LO];
        end
        if (BUS_WE && hit_ccb) begin
            st_nxt.mux_enable = BUS_WDATA[CCL_CCB_MUX_EN_BIT];
            st_nxt.tsrc = BUS_WDATA[CCL_CCB_TSRC_HI:CCL_CCB_TSRC_LO];
        end

        // flag: clear by ack or write-one, a new event wins
        if (IRQ_VECTOR_ACK || (BUS_WE && hit_ccs && BUS_WDATA[CCL_CCS_FLAG_BIT])) begin
            st_nxt.irq_flag = 1'b0;
        end
        if (irq_event) begin
            st_nxt.irq_flag = 1'b1;
        end

        // registered read data, unmapped reads as zero
        if (BUS_RE) begin
            if (hit_ccs) begin
                st_nxt.rdata = ccs_value;
            end else if (hit_ccb) begin
                st_nxt.rdata = ccb_value;
            end else begin
                st_nxt.rdata = CCL_ZERO_BYTE;
            end
        end

        if (RST) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        st_r <= st_nxt;
    end

    // outputs
    assign BUS_RDATA       = st_r.rdata;
    assign COMP_POWER_OFF  = st_r.comp_disable;
    assign POS_USE_BANDGAP = st_r.bandgap_sel;
    assign NEG_USE_CHANNEL = st_r.mux_enable && !CONVERTER_ENABLE;
    assign NEG_CHANNEL     = NEG_USE_CHANNEL ? CHANNEL_SELECT_LOW : 3'h0;
    assign COMP_IRQ        = st_r.irq_flag && st_r.irq_enable && GLOBAL_IRQ_ENABLE;
    assign CAPTURE_IN      = st_r.capture_en && comparator_output_bit;
    assign CONV_TRIGGER    = st_r.trig;

    // checks
    property p_sync_latency;
        @(posedge SYS_CLK) disable iff (RST)
        (COMP_RAW [*2]) |=> comparator_output_bit;
    endproperty
    a_sync_latency: assert property (p_sync_latency) else $error("output not synchronized in two cycles");

    property p_flag_set;
        @(posedge SYS_CLK) disable iff (RST)
        irq_event |=> st_r.irq_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

    property p_rise_mode;
        @(posedge SYS_CLK) disable iff (RST)
        (st_r.irq_mode == CCL_MODE_RISE) && $fell(comparator_output_bit) && !st_r.irq_flag && !$past(st_r.irq_flag)
            && !($past(comparator_output_bit) && !$past(st_r.aco_prev)) |=> !st_r.irq_flag;
    endproperty
    a_rise_mode: assert property (p_rise_mode) else $error("falling edge set flag in rising mode");

    property p_flag_clear;
        @(posedge SYS_CLK) disable iff (RST)
        IRQ_VECTOR_ACK && !irq_event |=> !st_r.irq_flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("vector did not clear flag");

    property p_irq_gate;
        @(posedge SYS_CLK) disable iff (RST)
        COMP_IRQ |-> GLOBAL_IRQ_ENABLE && st_r.irq_enable && ($past(irq_event) || $past(st_r.irq_flag));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("request without flag and enables");

    property p_mux_sel;
        @(posedge SYS_CLK) disable iff (RST)
        CONVERTER_ENABLE |-> !NEG_USE_CHANNEL;
    endproperty
    a_mux_sel: assert property (p_mux_sel) else $error("channel used while converter on");

    property p_capture_off;
        @(posedge SYS_CLK) disable iff (RST)
        !st_r.capture_en |-> !CAPTURE_IN;
    endproperty
    a_capture_off: assert property (p_capture_off) else $error("capture path active while disabled");

    property p_trig_gate;
        @(posedge SYS_CLK) disable iff (RST)
        CONV_TRIGGER |-> $past(AUTO_TRIGGER_ENABLE) && $past(CONVERTER_ENABLE);
    endproperty
    a_trig_gate: assert property (p_trig_gate) else $error("trigger without auto trigger and enable");

    property p_trig_rise;
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE && trig_sel && !st_r.trig_prev && !free_switch |=> CONV_TRIGGER;
    endproperty
    a_trig_rise: assert property (p_trig_rise) else $error("rising source edge gave no trigger");

    property p_free_switch;
        @(posedge SYS_CLK) disable iff (RST)
        free_switch |=> !CONV_TRIGGER;
    endproperty
    a_free_switch: assert property (p_free_switch) else $error("switch to free running triggered");

    property p_sync_low;
        @(posedge SYS_CLK) disable iff (RST)
        ((!COMP_RAW) [*2]) |=> !comparator_output_bit;
    endproperty
    a_sync_low: assert property (p_sync_low) else $error("low result not synchronized in two cycles");

    property p_out_read;
        @(posedge SYS_CLK) disable iff (RST)
        BUS_RE && hit_ccs |=> BUS_RDATA[CCL_CCS_OUTPUT_BIT] == $past(comparator_output_bit);
    endproperty
    a_out_read: assert property (p_out_read) else $error("output bit not readable");

    property p_io_read;
        @(posedge SYS_CLK) disable iff (RST)
        BUS_RE && BUS_IO && (BUS_ADDR == CCL_CCS_ADDR - CCL_IO_OFFSET)
            |=> BUS_RDATA[CCL_CCS_DISABLE_BIT] == $past(st_r.comp_disable);
    endproperty
    a_io_read: assert property (p_io_read) else $error("status not readable in io space");

    property p_power_off;
        @(posedge SYS_CLK) disable iff (RST)
        BUS_WE && hit_ccs |=> COMP_POWER_OFF == $past(BUS_WDATA[CCL_CCS_DISABLE_BIT]);
    endproperty
    a_power_off: assert property (p_power_off) else $error("comparator disable not applied");

    property p_bandgap;
        @(posedge SYS_CLK) disable iff (RST)
        BUS_WE && hit_ccs |=> POS_USE_BANDGAP == $past(BUS_WDATA[CCL_CCS_BANDGAP_BIT]);
    endproperty
    a_bandgap: assert property (p_bandgap) else $error("bandgap select not applied");

    property p_mux_use;
        @(posedge SYS_CLK) disable iff (RST)
        st_r.mux_enable && !CONVERTER_ENABLE |-> NEG_USE_CHANNEL && (NEG_CHANNEL == CHANNEL_SELECT_LOW);
    endproperty
    a_mux_use: assert property (p_mux_use) else $error("channel not used as negative input");

    property p_mux_off;
        @(posedge SYS_CLK) disable iff (RST)
        !st_r.mux_enable |-> !NEG_USE_CHANNEL;
    endproperty
    a_mux_off: assert property (p_mux_off) else $error("channel used while mux disabled");

    property p_capture_on;
        @(posedge SYS_CLK) disable iff (RST)
        st_r.capture_en |-> CAPTURE_IN == comparator_output_bit;
    endproperty
    a_capture_on: assert property (p_capture_on) else $error("capture path does not follow output");

    property p_toggle_set;
        @(posedge SYS_CLK) disable iff (RST)
        (st_r.irq_mode == CCL_MODE_TOGGLE) && $changed(comparator_output_bit) |=> st_r.irq_flag;
    endproperty
    a_toggle_set: assert property (p_toggle_set) else $error("toggle did not set flag");

    property p_fall_set;
        @(posedge SYS_CLK) disable iff (RST)
        (st_r.irq_mode == CCL_MODE_FALL) && $fell(comparator_output_bit) |=> st_r.irq_flag;
    endproperty
    a_fall_set: assert property (p_fall_set) else $error("falling edge did not set flag");

    property p_rise_set;
        @(posedge SYS_CLK) disable iff (RST)
        (st_r.irq_mode == CCL_MODE_RISE) && $rose(comparator_output_bit) |=> st_r.irq_flag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rising edge did not set flag");

    property p_mode_reserved;
        @(posedge SYS_CLK) disable iff (RST)
        (st_r.irq_mode == CCL_MODE_RESERVED) && !st_r.irq_flag |=> !st_r.irq_flag;
    endproperty
    a_mode_reserved: assert property (p_mode_reserved) else $error("reserved mode set flag");

    property p_write_clear;
        @(posedge SYS_CLK) disable iff (RST)
        BUS_WE && hit_ccs && BUS_WDATA[CCL_CCS_FLAG_BIT] && !irq_event |=> !st_r.irq_flag;
    endproperty
    a_write_clear: assert property (p_write_clear) else $error("write one did not clear flag");

    property p_trig_pulse;
        @(posedge SYS_CLK) disable iff (RST)
        CONV_TRIGGER |=> !CONV_TRIGGER;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than one cycle");

    property p_trig_ext;
        @(posedge SYS_CLK) disable iff (RST)
        AUTO_TRIGGER_ENABLE && CONVERTER_ENABLE && (st_r.tsrc == CCL_TSRC_EXT0) && $stable(st_r.tsrc)
            && $rose(EXT_INT0_FLAG) |=> CONV_TRIGGER;
    endproperty
    a_trig_ext: assert property (p_trig_ext) else $error("source flag rise gave no trigger");
endmodule

// ---- testbench/ccl_analog.sv ----
// Purpose: analog comparator core and conversion start counter
// Assumes: converter channel n sits at 100*n+50 mV
// Notes:   a powered-off comparator reads low
`timescale 1ns/10ps
module ccl_analog (
    // clock and analog levels
    input  wire logic       sys_clk,
    input  int              pos_mv,
    input  int              neg_mv,
    // comparator controls
    input  wire logic       power_off,
    input  wire logic       use_bg,
    input  wire logic       use_ch,
    input  wire logic [2:0] ch,
    output logic            raw,
    // conversion start
    input  wire logic       trig,
    output int              trig_cnt
);
    localparam int BANDGAP_MV = 1100;
    int p;
    int n;
    int cnt = 0;
    always_comb begin
        p = use_bg ? BANDGAP_MV : pos_mv;
        n = use_ch ? 100 * int'(ch) + 50 : neg_mv;
        raw = !power_off && (p > n);
    end
    assign trig_cnt = cnt;
    always @(posedge sys_clk) begin
        if (trig) begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the comparator control logic
// Assumes: inputs driven on the falling clock edge
// Notes:   i/o-space accesses are those at or below the i/o window top
`timescale 1ns/10ps
module tb;
    import ccl_pkg::*;
    localparam logic [7:0] CS = CCL_CCS_ADDR;
    localparam logic [7:0] CB = CCL_CCB_ADDR;
    localparam logic [7:0] IO = CCL_CCS_ADDR - CCL_IO_OFFSET;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic       io = 1'b0;
    logic       we = 1'b0;
    logic       re = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       raw, pwr_off, use_bg, use_ch, irq, cap, ctrig;
    logic [2:0] neg_ch;
    logic       conv_en = 1'b0;
    logic       auto_en = 1'b0;
    logic [2:0] chan = 3'h0;
    logic       done = 1'b0;
    logic [5:0] tf = 6'h00;
    logic       gie = 1'b1;
    logic       ack = 1'b0;
    int         pos_mv = 0;
    int         neg_mv = 500;
    int         trig_cnt;
    int         num_errors = 0;
    int         comparisons = 0;
    int         cycles = 0;
    ccl_top ccl_top_i (
        .SYS_CLK(clk), .RST(rst), .BUS_ADDR(addr), .BUS_IO(io), .BUS_WE(we), .BUS_RE(re),
        .BUS_WDATA(wdata), .BUS_RDATA(rdata), .COMP_RAW(raw), .COMP_POWER_OFF(pwr_off),
        .POS_USE_BANDGAP(use_bg), .NEG_USE_CHANNEL(use_ch), .NEG_CHANNEL(neg_ch),
        .CONVERTER_ENABLE(conv_en), .AUTO_TRIGGER_ENABLE(auto_en), .CHANNEL_SELECT_LOW(chan),
        .CONVERSION_DONE_FLAG(done), .EXT_INT0_FLAG(tf[0]), .T0_CMPA_FLAG(tf[1]),
        .T0_OVF_FLAG(tf[2]), .T1_CMPB_FLAG(tf[3]), .T1_OVF_FLAG(tf[4]), .T1_CAPT_FLAG(tf[5]),
        .GLOBAL_IRQ_ENABLE(gie), .IRQ_VECTOR_ACK(ack), .COMP_IRQ(irq), .CAPTURE_IN(cap),
        .CONV_TRIGGER(ctrig)
    );
    ccl_analog ccl_analog_i (
        .sys_clk(clk), .pos_mv(pos_mv), .neg_mv(neg_mv), .power_off(pwr_off), .use_bg(use_bg),
        .use_ch(use_ch), .ch(neg_ch), .raw(raw), .trig(ctrig), .trig_cnt(trig_cnt)
    );
    always #12.5 clk = ~clk;
    task automatic end_sim;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io = (a <= CCL_IO_LAST);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        io = (a <= CCL_IO_LAST);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        chk("rdata", e, rdata);
    endtask
    task automatic trig(input logic [5:0] f, input int d);
        int n;
        n = trig_cnt;
        tf = f;
        cyc(3);
        tf = 6'h00;
        cyc(2);
        chk("triggers", 8'(d), 8'(trig_cnt - n));
    endtask
    task automatic t_reg;
        rd(CS, 8'h00);
        rd(CB, 8'h00);
        wr(CB, 8'hff);
        rd(CB, 8'h47);
        wr(IO, 8'hc4);
        chk("power_off", 8'h01, 8'(pwr_off));
        chk("bandgap", 8'h01, 8'(use_bg));
        rd(IO, 8'hc4);
        rd(8'h51, 8'h00);
        wr(CB, 8'h00);
        wr(CS, 8'h40);
        cyc(4);
        rd(CS, 8'h70);
        wr(CS, 8'h30);
        cyc(4);
        rd(CS, 8'h10);
    endtask
    task automatic t_mux;
        wr(CS, 8'h14);
        wr(CB, 8'h40);
        pos_mv = 400;
        for (int c = 0; c < 8; c++) begin
            chan = 3'(c);
            cyc(4);
            chk("neg_use", 8'h01, 8'(use_ch));
            chk("neg_ch", 8'(c), 8'(neg_ch));
            chk("capture", 8'(c < 4), 8'(cap));
        end
        chan = 3'h0;
        cyc(4);
        chk("capture", 8'h01, 8'(cap));
        conv_en = 1'b1;
        cyc(4);
        chk("neg_use", 8'h00, 8'(use_ch));
        chk("capture", 8'h00, 8'(cap));
        conv_en = 1'b0;
        wr(CB, 8'h07);
        chk("neg_use", 8'h00, 8'(use_ch));
        pos_mv = 900;
        cyc(2);
        chk("capture", 8'h01, 8'(cap));
        wr(CS, 8'h10);
        chk("capture", 8'h00, 8'(cap));
        pos_mv = 0;
        cyc(4);
    endtask
    task automatic t_irq;
        logic [1:0] m;
        logic       fr;
        logic       ff;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            fr = (m == CCL_MODE_TOGGLE) || (m == CCL_MODE_RISE);
            ff = (m == CCL_MODE_TOGGLE) || (m == CCL_MODE_FALL);
            wr(CS, {6'h04, m});
            wr(CS, {6'h02, m});
            pos_mv = 900;
            cyc(4);
            rd(CS, {3'h1, fr, 2'h2, m});
            chk("irq", 8'(fr), 8'(irq));
            wr(CS, {6'h06, m});
            pos_mv = 0;
            cyc(4);
            rd(CS, {3'h0, ff, 2'h2, m});
            ack = 1'b1;
            cyc(1);
            ack = 1'b0;
            rd(CS, {4'h0, 2'h2, m});
            wr(CS, {6'h00, m});
        end
        wr(CS, 8'h00);
        wr(CS, 8'h08);
        pos_mv = 900;
        gie = 1'b0;
        cyc(4);
        chk("irq", 8'h00, 8'(irq));
        gie = 1'b1;
        cyc(1);
        chk("irq", 8'h01, 8'(irq));
        wr(CS, 8'h10);
    endtask
    task automatic t_trig;
        int n;
        conv_en = 1'b1;
        auto_en = 1'b1;
        for (int s = 2; s < 8; s++) begin
            wr(CB, 8'(s));
            trig(6'h01 << (s - 2), 1);
        end
        wr(CB, 8'h02);
        n = trig_cnt;
        tf = 6'h02;
        wr(CB, 8'h03);
        cyc(2);
        chk("triggers", 8'h01, 8'(trig_cnt - n));
        tf = 6'h00;
        done = 1'b1;
        wr(CB, 8'h00);
        cyc(3);
        chk("triggers", 8'h01, 8'(trig_cnt - n));
        done = 1'b0;
        cyc(2);
        done = 1'b1;
        cyc(3);
        chk("triggers", 8'h02, 8'(trig_cnt - n));
        done = 1'b0;
        wr(CS, 8'h10);
        wr(CB, 8'h01);
        n = trig_cnt;
        pos_mv = 0;
        cyc(6);
        chk("triggers", 8'h01, 8'(trig_cnt - n));
        wr(CB, 8'h04);
        auto_en = 1'b0;
        trig(6'h04, 0);
        auto_en = 1'b1;
        conv_en = 1'b0;
        trig(6'h04, 0);
        conv_en = 1'b1;
        trig(6'h04, 1);
    endtask
    initial begin
        cyc(2);
        rst = 1'b0;
        t_reg();
        t_mux();
        t_irq();
        t_trig();
        end_sim();
    end
endmodule
